/* File: tlipu_core.sv */
// two-level interrupt enable, priority arbitration and nesting tracker
`timescale 1ns/1ps

// Functional notes
// - every source has one priority bit picking low or high level
// - high level preempts a low routine; a high routine is never preempted
// - all priority bits read low level after reset
// - high level wins over low; equal levels resolved by fixed source order
// - 22 sources, lower index wins; vector is 0x0003 plus eight per index
// - pending requests are sampled and arbitrated every clock
// - fastest response is one detect clock plus four long call clocks
// - pending at return: one more instruction runs before the long call
// - worst case is 18 clocks: detect, return, divide and long call
// - equal or higher active level: wait for return plus one instruction
// - global gate bit 7 of basic mask overrides every individual mask
// - basic mask bit 6 is a plain software flag with no effect
// - basic mask bits 0 to 5 enable the six classic sources
// - basic level bits 0 to 5 select high level for the same sources
// - basic level bits 7 and 6 read ones and ignore writes
// - extended mask one enables sources 6 to 13 in order
// - extended mask two enables sources 14 to 21 in order
// - extended level one selects high level for sources 6 to 13
// - extended level two selects level for 14 to 21, resets to zero
// - all six registers decode with no regard to register page
// - flag still set after return raises a fresh request once the next instruction ends
module tlipu_core
	import tlipu_pkg::*;
(
	input  wire logic                 sys_clk_i,
	input  wire logic                 srst_i,
	input  wire tlipu_sfr_req_s       sfr_i,
	output logic       [SFR_W-1:0]    sfr_rdata_o,
	input  wire logic  [NUM_SRC-1:0]  pend_i,
	input  wire logic                 irq_ack_i,
	input  wire logic                 return_from_service_done_i,
	input  wire logic                 instr_done_i,
	output logic                      irq_req_o,
	output tlipu_grant_s              grant_o,
	output logic                      active_low_o,
	output logic                      active_high_o
);

	logic [7:0]          mask_basic;
	logic [5:0]          level_basic;
	logic [7:0]          mask_ext1;
	logic [7:0]          mask_ext2;
	logic [7:0]          level_ext1;
	logic [7:0]          level_ext2;
	logic [NUM_SRC-1:0]  mask_all;
	logic [NUM_SRC-1:0]  level_all;
	logic [NUM_SRC-1:0]  enabled;
	logic [NUM_SRC-1:0]  hi_req;
	logic [NUM_SRC-1:0]  lo_req;
	logic                hi_any;
	logic                lo_any;
	logic                blocked;
	logic                hold_next_instr;
	logic [1:0]          call_cnt;
	logic                next_req;
	tlipu_grant_s        next_grant;
	logic                wr_mask_basic;
	logic                wr_level_basic;
	logic                wr_mask_ext1;
	logic                wr_mask_ext2;
	logic                wr_level_ext1;
	logic                wr_level_ext2;

	// lowest set index of a request vector
	function automatic logic [SRC_W-1:0] lowest_idx(
		input logic [NUM_SRC-1:0] vec
	);
		logic [SRC_W-1:0] idx;
		idx = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (vec[i]) begin
				idx = SRC_W'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [VEC_W-1:0] vec_of(
		input logic [SRC_W-1:0] idx
	);
		return VEC_BASE + (VEC_W'(idx) << VEC_STEP_LOG2);
	endfunction

	always_comb begin
		wr_mask_basic  = sfr_i.wr && (sfr_i.addr == ADDR_MASK_BASIC);
		wr_level_basic = sfr_i.wr && (sfr_i.addr == ADDR_LEVEL_BASIC);
		wr_mask_ext1   = sfr_i.wr && (sfr_i.addr == ADDR_MASK_EXT1);
		wr_mask_ext2   = sfr_i.wr && (sfr_i.addr == ADDR_MASK_EXT2);
		wr_level_ext1  = sfr_i.wr && (sfr_i.addr == ADDR_LEVEL_EXT1);
		wr_level_ext2  = sfr_i.wr && (sfr_i.addr == ADDR_LEVEL_EXT2);
	end

	// basic mask with gate and spare flag
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			mask_basic <= RST_MASK;
		end else if (wr_mask_basic) begin
			mask_basic <= sfr_i.wdata;
		end
	end

	// upper level bits are not stored
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			level_basic <= RST_LEVEL_BASE;
		end else if (wr_level_basic) begin
			level_basic <= sfr_i.wdata[BASIC_SRC_W-1:0];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			mask_ext1 <= RST_MASK;
		end else if (wr_mask_ext1) begin
			mask_ext1 <= sfr_i.wdata;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			mask_ext2 <= RST_MASK;
		end else if (wr_mask_ext2) begin
			mask_ext2 <= sfr_i.wdata;
		end
	end

	// levels clear to low on reset
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			level_ext1 <= RST_LEVEL;
		end else if (wr_level_ext1) begin
			level_ext1 <= sfr_i.wdata;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			level_ext2 <= RST_LEVEL;
		end else if (wr_level_ext2) begin
			level_ext2 <= sfr_i.wdata;
		end
	end

	// read-back, unused level bits return ones
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			sfr_rdata_o <= RD_UNMAPPED;
		end else if (sfr_i.rd) begin
			case (sfr_i.addr)
				ADDR_MASK_BASIC:  sfr_rdata_o <= mask_basic;
				ADDR_LEVEL_BASIC: sfr_rdata_o <= {LEVEL_FILL, level_basic};
				ADDR_MASK_EXT1:   sfr_rdata_o <= mask_ext1;
				ADDR_MASK_EXT2:   sfr_rdata_o <= mask_ext2;
				ADDR_LEVEL_EXT1:  sfr_rdata_o <= level_ext1;
				ADDR_LEVEL_EXT2:  sfr_rdata_o <= level_ext2;
				default:          sfr_rdata_o <= RD_UNMAPPED;
			endcase
		end
	end

	// source order across the three mask registers
	always_comb begin
		mask_all  = {mask_ext2, mask_ext1, mask_basic[BASIC_SRC_W-1:0]};
		level_all = {level_ext2, level_ext1, level_basic};
	end

	// gate overrides masks; split by level
	always_comb begin
		enabled = pend_i & mask_all & {NUM_SRC{mask_basic[GATE_BIT]}};
		hi_req  = enabled & level_all;
		lo_req  = enabled & ~level_all;
		hi_any  = |hi_req;
		lo_any  = |lo_req;
	end

	// hold while a call, return or its follow-up is in flight
	always_comb begin
		blocked = hold_next_instr || return_from_service_done_i || irq_ack_i
			|| (call_cnt != 2'h0) || active_high_o;
	end

	// high first, then lowest index; preemption
	always_comb begin
		next_req   = 1'b0;
		next_grant = grant_o;
		if (!blocked) begin
			if (hi_any) begin
				next_req          = 1'b1;
				next_grant.src    = lowest_idx(hi_req);
				next_grant.level  = 1'b1;
			end else if (lo_any && !active_low_o) begin
				next_req          = 1'b1;
				next_grant.src    = lowest_idx(lo_req);
				next_grant.level  = 1'b0;
			end
		end
		next_grant.vector = vec_of(next_grant.src);
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			irq_req_o <= 1'b0;
			grant_o   <= '0;
		end else begin
			irq_req_o <= next_req;
			grant_o   <= next_grant;
		end
	end

	// quiet for the long call once taken
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			call_cnt <= 2'h0;
		end else if (irq_ack_i && irq_req_o) begin
			call_cnt <= CALL_HOLD_LOAD;
		end else if (call_cnt != 2'h0) begin
			call_cnt <= call_cnt - 2'h1;
		end
	end

	// one instruction must finish after a return
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			hold_next_instr <= 1'b0;
		end else if (return_from_service_done_i) begin
			hold_next_instr <= 1'b1;
		end else if (instr_done_i) begin
			hold_next_instr <= 1'b0;
		end
	end

	// active level tracking, return closes the innermost level
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			active_low_o  <= 1'b0;
			active_high_o <= 1'b0;
		end else begin
			if (return_from_service_done_i) begin
				if (active_high_o) begin
					active_high_o <= 1'b0;
				end else begin
					active_low_o <= 1'b0;
				end
			end
			if (irq_ack_i && irq_req_o) begin
				if (grant_o.level) begin
					active_high_o <= 1'b1;
				end else begin
					active_low_o <= 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (srst_i);

	gate_block_a: assert property (
		!mask_basic[GATE_BIT] |=> !irq_req_o
	) else $error("request raised with global gate off");

	high_nopreempt_a: assert property (
		active_high_o |=> !irq_req_o
	) else $error("request raised during high level routine");

	low_preempt_a: assert property (
		irq_req_o && $past(active_low_o) |-> grant_o.level
	) else $error("low request raised during low level routine");

	level_reset_a: assert property (
		$fell(srst_i) |-> (level_all == '0)
	) else $error("priority bits not low after reset");

	high_first_a: assert property (
		irq_req_o && !grant_o.level |-> !$past(hi_any)
	) else $error("low request chosen over high request");

	vector_map_a: assert property (
		irq_req_o |-> grant_o.vector
			== VEC_BASE + (VEC_W'(grant_o.src) << VEC_STEP_LOG2)
	) else $error("vector does not match source index");

	detect_one_a: assert property (
		(hi_any && !blocked) |=> irq_req_o && grant_o.level
	) else $error("eligible request not raised next clock");

	call_quiet_a: assert property (
		irq_ack_i && irq_req_o |=> !irq_req_o [*4]
	) else $error("request raised during long call");

	return_from_service_wait_a: assert property (
		return_from_service_done_i ##1 !instr_done_i [*2] |=> !irq_req_o
	) else $error("request raised before post-return instruction ended");

	level_fill_a: assert property (
		sfr_i.rd && sfr_i.addr == ADDR_LEVEL_BASIC
			|=> sfr_rdata_o[7:6] == LEVEL_FILL
	) else $error("unused level bits not read as ones");

	refire_a: assert property (
		hold_next_instr && instr_done_i && !return_from_service_done_i
			##1 !blocked && (hi_any || (lo_any && !active_low_o))
			|=> irq_req_o
	) else $error("still-pending source not re-raised after return");

	// worst case needs no extra state: return, divide and call
	// all run in the core while the hold and call counter keep us quiet
	nest_track_a: assert property (
		irq_ack_i && irq_req_o && grant_o.level && !return_from_service_done_i
			|=> active_high_o
	) else $error("high level not marked active after call");

	call_end_a: assert property (
		irq_ack_i && irq_req_o |-> ##4 (call_cnt == 2'h0)
	) else $error("long call quiet window did not end");

	hold_release_a: assert property (
		hold_next_instr && instr_done_i && !return_from_service_done_i
			|=> !hold_next_instr
	) else $error("return hold outlived the following instruction");

	low_wait_a: assert property (
		active_low_o && !hi_any |=> !irq_req_o
	) else $error("request raised in low routine with no high source");

	spare_read_a: assert property (
		sfr_i.rd && sfr_i.addr == ADDR_MASK_BASIC
			|=> sfr_rdata_o == $past(mask_basic)
	) else $error("basic mask read-back lost a bit");

endmodule

/* File: tlipu_pkg.sv */
// constants and carrier types for the two-level interrupt priority unit
package tlipu_pkg;

	// source count and widths
	localparam int unsigned NUM_SRC       = 22;
	localparam int unsigned SRC_W         = 5;
	localparam int unsigned VEC_W         = 16;
	localparam int unsigned SFR_W         = 8;

	// register addresses on the special-function register bus
	localparam logic [7:0] ADDR_MASK_BASIC  = 8'ha8;
	localparam logic [7:0] ADDR_LEVEL_BASIC = 8'hb8;
	localparam logic [7:0] ADDR_MASK_EXT1   = 8'he6;
	localparam logic [7:0] ADDR_MASK_EXT2   = 8'he7;
	localparam logic [7:0] ADDR_LEVEL_EXT1  = 8'hf6;
	localparam logic [7:0] ADDR_LEVEL_EXT2  = 8'hf7;

	// reset values
	localparam logic [7:0] RST_MASK       = 8'h00;
	localparam logic [7:0] RST_LEVEL      = 8'h00;
	localparam logic [5:0] RST_LEVEL_BASE = 6'h00;
	localparam logic [7:0] RD_UNMAPPED    = 8'h00;

	// field positions
	localparam int unsigned GATE_BIT      = 7;
	localparam int unsigned SPARE_BIT     = 6;
	localparam int unsigned BASIC_SRC_W   = 6;
	localparam logic [1:0]  LEVEL_FILL    = 2'h3;

	// service vectors: base plus eight bytes per source index
	localparam logic [15:0] VEC_BASE      = 16'h0003;
	localparam int unsigned VEC_STEP_LOG2 = 3;

	// response timing in system clocks
	localparam int unsigned DETECT_CYCLES = 1;
	localparam int unsigned CALL_CYCLES   = 4;
	localparam int unsigned RETURN_FROM_SERVICE_CYCLES   = 5;
	localparam int unsigned DIV_CYCLES    = 8;
	localparam int unsigned MIN_RESPONSE  = DETECT_CYCLES + CALL_CYCLES;
	localparam int unsigned MAX_RESPONSE  = DETECT_CYCLES + RETURN_FROM_SERVICE_CYCLES
		+ DIV_CYCLES + CALL_CYCLES;
	localparam logic [1:0]  CALL_HOLD_LOAD = 2'(CALL_CYCLES - 1);

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} tlipu_sfr_req_s;

	typedef struct packed {
		logic [SRC_W-1:0] src;
		logic             level;
		logic [VEC_W-1:0] vector;
	} tlipu_grant_s;

endpackage

/* File: tlipu_core_model.sv */
// behavioural cpu core answering the request line
`timescale 1ns/1ps
module tlipu_core_model (
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       req_i,
	input  wire logic       ack_en_i,
	input  wire logic [3:0] ack_dly_i,
	input  wire logic       ret_go_i,
	input  wire logic [3:0] gap_i,
	output logic            ack_o,
	output logic            return_from_service_o,
	output logic            instr_o
);
	logic [3:0] wait_c;
	logic [3:0] gap_c;
	always_ff @(posedge clk_i) begin
		ack_o   <= 1'b0;
		return_from_service_o  <= 1'b0;
		instr_o <= 1'b0;
		wait_c  <= 4'h0;
		if (srst_i) begin
			gap_c <= 4'h0;
		end else begin
			if (req_i && ack_en_i && !ack_o) begin
				if (wait_c >= ack_dly_i)
					ack_o <= 1'b1;
				else
					wait_c <= wait_c + 4'h1;
			end
			if (ret_go_i) begin
				return_from_service_o <= 1'b1;
				gap_c  <= gap_i;
			end else if (gap_c == 4'h1) begin
				instr_o <= 1'b1;
				gap_c   <= 4'h0;
			end else if (gap_c != 4'h0) begin
				gap_c <= gap_c - 4'h1;
			end
		end
	end
endmodule

/* File: tb_top.sv */
// self-checking bench for the interrupt priority unit
`timescale 1ns/1ps
module tb_top;
	import tlipu_pkg::*;
	logic                 sys_clk_i = 1'b0;
	logic                 srst_i = 1'b1;
	tlipu_sfr_req_s       special_function_register = '0;
	logic [SFR_W-1:0]     rdata;
	logic [NUM_SRC-1:0]   pend = '0;
	logic                 ack, return_from_service, instr, req, act_l, act_h;
	tlipu_grant_s         grant;
	logic                 ack_en = 1'b0, ret_go = 1'b0;
	logic [3:0]           ack_dly = 4'h0, gap = 4'h1;
	logic [7:0]           ie, ip, e1, e2, p1, p2;
	int                   n_errors = 0, tests_run = 0, seed = 32'h2200;

	always #4 sys_clk_i = ~sys_clk_i;

	tlipu_core i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .sfr_i(special_function_register),
		.sfr_rdata_o(rdata), .pend_i(pend), .irq_ack_i(ack),
		.return_from_service_done_i(return_from_service), .instr_done_i(instr), .irq_req_o(req),
		.grant_o(grant), .active_low_o(act_l), .active_high_o(act_h));
	tlipu_core_model i_core (.clk_i(sys_clk_i), .srst_i(srst_i), .req_i(req),
		.ack_en_i(ack_en), .ack_dly_i(ack_dly), .ret_go_i(ret_go),
		.gap_i(gap), .ack_o(ack), .return_from_service_o(return_from_service), .instr_o(instr));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i) special_function_register <= '{a, 1'b1, 1'b0, d};
		@(posedge sys_clk_i) special_function_register <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk_i) special_function_register <= '{a, 1'b0, 1'b1, 8'h00};
		@(posedge sys_clk_i) special_function_register <= '0;
		#1 chk(rdata, e);
	endtask

	// reference arbiter: returns source plus 32 times level, or -1
	function automatic int win(input logic [21:0] p, m, l, input logic g);
		int r = -1;
		for (int lv = 0; lv < 2; lv++)
			for (int i = NUM_SRC - 1; i >= 0; i--)
				if (g && p[i] && m[i] && l[i] == lv)
					r = i + 32 * lv;
		return r;
	endfunction

	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_errors++;
		complete_run;
	end

	initial begin
		int e;
		int i;
		logic early;
		repeat (5) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		rd(ADDR_MASK_BASIC, 8'h00);
		rd(ADDR_LEVEL_BASIC, 8'hc0);
		rd(ADDR_MASK_EXT1, 8'h00);
		rd(ADDR_MASK_EXT2, 8'h00);
		rd(ADDR_LEVEL_EXT1, 8'h00);
		rd(ADDR_LEVEL_EXT2, 8'h00);
		rd(8'h87, 8'h00);
		for (int k = 0; k < 40; k++) begin
			ie = 8'($random(seed));
			ie[7] = (k % 8 != 0);
			{ip, e1, e2, p1, p2} = 40'({$random(seed), $random(seed)});
			wr(ADDR_MASK_BASIC, ie);
			wr(ADDR_LEVEL_BASIC, ip);
			wr(ADDR_MASK_EXT1, e1);
			wr(ADDR_MASK_EXT2, e2);
			wr(ADDR_LEVEL_EXT1, p1);
			wr(ADDR_LEVEL_EXT2, p2);
			@(posedge sys_clk_i) pend <= 22'($random(seed));
			repeat (2) @(posedge sys_clk_i);
			#1 e = win(pend, {e2, e1, ie[5:0]}, {p2, p1, ip[5:0]}, ie[7]);
			chk(req, e >= 0);
			if (e >= 0) begin
				chk(grant.src, e % 32);
				chk(grant.level, e / 32);
				chk(grant.vector, 3 + 8 * (e % 32));
			end
			rd(ADDR_LEVEL_BASIC, {2'b11, ip[5:0]});
			rd(ADDR_MASK_BASIC, ie);
		end
		@(posedge sys_clk_i) pend <= '0;
		wr(ADDR_MASK_BASIC, 8'h83);
		wr(ADDR_LEVEL_BASIC, 8'h02);
		@(posedge sys_clk_i) ack_en <= 1'b1;
		pend <= 22'h1;
		for (i = 0; i < 20 && !act_l; i++) @(posedge sys_clk_i);
		pend <= '0;
		ack_dly <= 4'h3;
		#1 chk(act_l, 1);
		@(posedge sys_clk_i) pend <= 22'h2;
		for (i = 0; i < 20 && !act_h; i++) @(posedge sys_clk_i);
		pend <= 22'h1;
		#1 chk(grant.vector, 16'h000b);
		chk({act_h, act_l}, 2'b11);
		repeat (8) @(posedge sys_clk_i);
		#1 chk(req, 0);
		@(posedge sys_clk_i) ret_go <= 1'b1;
		@(posedge sys_clk_i) ret_go <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
		#1 chk({act_h, act_l, req}, 3'b010);
		@(posedge sys_clk_i) ack_en <= 1'b0;
		gap <= 4'h8;
		ret_go <= 1'b1;
		@(posedge sys_clk_i) ret_go <= 1'b0;
		early = 1'b0;
		for (i = 0; i < 20 && !instr; i++) begin
			@(posedge sys_clk_i);
			#1 early = early | req;
		end
		for (i = 0; i < 4 && !req; i++) @(posedge sys_clk_i);
		#1 chk(early, 0);
		chk({req, grant.src}, {1'b1, 5'd0});
		complete_run;
	end
endmodule
